//--- ddsc_host_model.sv
// Host model that drives the register port of the slew controller
`timescale 1ns/10ps
module ddsc_host_model
   import ddsc_pkg::*;
(
   input wire logic mclk,
   output logic [DDSC_ADDR_W-1:0] reg_addr,
   output logic [DDSC_DATA_W-1:0] reg_wdata,
   output logic reg_wr,
   output logic reg_rd,
   input wire logic [DDSC_DATA_W-1:0] reg_rdata
);
   initial begin
      reg_addr = 4'hf;
      reg_wdata = 16'h0000;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
   end

   task automatic wr(input logic [3:0] a, input logic [15:0] d);
      @(posedge mclk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge mclk);
      reg_wr <= 1'b0;
      // Stale data is not left on the bus
      reg_wdata <= ~d;
   endtask : wr

   task automatic rd(input logic [3:0] a, output logic [15:0] d);
      @(posedge mclk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge mclk);
      reg_rd <= 1'b0;
      #1;
      d = reg_rdata;
   endtask : rd

   // Polls slew idle, for at most 400 status reads, so that a write does not halt a ramp by accident
   task automatic wait_idle();
      logic [15:0] s;
      s = 16'h0001;
      for (int i = 0; i < 400 && s[DDSC_ST_ACTIVE_BIT] !== 1'b0; i++) begin
         rd(DDSC_REG_STATUS, s);
      end
   endtask : wait_idle
endmodule : ddsc_host_model

//--- ddsc_pkg.sv
// Constants shared by the DAC digital slew controller
package ddsc_pkg;

   // Register port
   localparam int DDSC_ADDR_W = 4;
   localparam int DDSC_DATA_W = 16;

   // Register indices
   localparam logic [3:0] DDSC_REG_DATA = 4'h0;
   localparam logic [3:0] DDSC_REG_CTRL = 4'h1;
   localparam logic [3:0] DDSC_REG_STATUS = 4'h2;
   localparam logic [3:0] DDSC_REG_INT_STAT = 4'h3;
   localparam logic [3:0] DDSC_REG_INT_MASK = 4'h4;
   localparam logic [3:0] DDSC_REG_CODE = 4'h5;

   // Control register fields
   localparam int DDSC_INC_LSB = 0;
   localparam int DDSC_INC_W = 3;
   localparam int DDSC_RATE_LSB = 3;
   localparam int DDSC_RATE_W = 4;
   localparam int DDSC_EN_BIT = 7;
   localparam int DDSC_CTRL_W = 8;
   localparam logic [7:0] DDSC_CTRL_RST = 8'h00;

   // Status register fields
   localparam int DDSC_ST_ACTIVE_BIT = 0;
   localparam int DDSC_ST_CLEAR_BIT = 1;

   // Interrupt status and mask fields
   localparam int DDSC_INT_W = 3;
   localparam int DDSC_INT_DONE = 0;
   localparam int DDSC_INT_REFUSED = 1;
   localparam int DDSC_INT_CLEAR = 2;
   localparam logic [2:0] DDSC_INT_RST = 3'h0;
   localparam logic [2:0] DDSC_MASK_RST = 3'h0;

   // Internal code carries four fraction bits for the 12-bit variant
   localparam int DDSC_CODE_W = 16;
   localparam logic [15:0] DDSC_CODE_RST = 16'h0000;
   localparam logic [15:0] DDSC_ZERO_SCALE = 16'h0000;

   // Clock and update tick rates
   localparam int DDSC_CLK_HZ = 125_000_000;
   localparam int DDSC_DIV_W = 24;
   localparam int DDSC_RATE_HZ [16] = '{
      257730, 198410, 152440, 131580, 115740, 69440, 37590, 25770,
      20160, 16030, 10290, 8280, 6900, 5530, 4240, 3300
   };

endpackage : ddsc_pkg

//--- ddsc_slew_ctrl.sv
// DAC digital slew controller: register port, ramp engine, interrupt
//
// Notes on behaviour
// [RL1] Slew disabled: new code applied at once
// [RL2] Slew enabled: output steps toward each target
// [RL3] Rate field selects tick from sixteen frequencies
// [RL4] Increment field k steps two-to-k fine units
// [RL5] Enabled: every change follows the slew pace
// [RL6] Clear while enabled ramps to zero scale
// [RL7] Control write during ramp halts the output
// [RL8] Host waits for slew idle before writing
// [RL9] Tick rate independent of output range
// [RL10] One step per tick, staircase ramp
// [RL11] Slew active flag high while still stepping
// [RL12] Clear high forces bottom, refuses new data
// [RL13] Last step clipped to land on target
//
// Implementation choices: the address map and the strobed register port.
`timescale 1ns/10ps
module ddsc_slew_ctrl
   import ddsc_pkg::*;
#(
   parameter int RES_BITS = 16,
   parameter int CLK_FREQ_HZ = DDSC_CLK_HZ
) (
   input wire logic mclk,
   input wire logic reset_n,
   input wire logic [DDSC_ADDR_W-1:0] reg_addr,
   input wire logic [DDSC_DATA_W-1:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [DDSC_DATA_W-1:0] reg_rdata,
   input wire logic clear_in,
   output logic [RES_BITS-1:0] dac_code,
   output logic slew_active,
   output logic irq
);

   localparam int FRAC = DDSC_CODE_W - RES_BITS;

   logic [DDSC_CTRL_W-1:0] ctrl_r;
   logic [DDSC_CTRL_W-1:0] ctrl_nxt;
   logic [DDSC_CODE_W-1:0] code_r;
   logic [DDSC_CODE_W-1:0] code_nxt;
   logic [DDSC_CODE_W-1:0] target_r;
   logic [DDSC_CODE_W-1:0] target_nxt;
   logic clr_q_r;
   logic clr_q_nxt;
   logic act_q_r;
   logic act_q_nxt;
   logic [DDSC_INT_W-1:0] int_r;
   logic [DDSC_INT_W-1:0] int_nxt;
   logic [DDSC_INT_W-1:0] mask_r;
   logic [DDSC_INT_W-1:0] mask_nxt;
   logic [DDSC_DATA_W-1:0] rdata_r;
   logic [DDSC_DATA_W-1:0] rdata_nxt;

   logic slew_en;
   logic [DDSC_CODE_W-1:0] step;
   logic [DDSC_CODE_W-1:0] wr_code;
   logic data_wr;
   logic ctrl_wr;
   logic clr_rise;
   logic refused;
   logic [DDSC_INT_W-1:0] events;

   ddsc_tick_if tk ();

   ddsc_tick_gen #(
      .CLK_FREQ_HZ(CLK_FREQ_HZ)
   ) u_tick (
      .mclk(mclk),
      .reset_n(reset_n),
      .tk(tk)
   );

   function automatic logic ddsc_hit(input logic [DDSC_ADDR_W-1:0] a,
                                     input logic [3:0] idx);
      return a == idx;
   endfunction : ddsc_hit

   assign slew_en = ctrl_r[DDSC_EN_BIT];
   // Fine units are 1/16 LSB on the 12-bit variant, so 2^k works for both
   assign step = DDSC_CODE_W'(1) << ctrl_r[DDSC_INC_LSB +: DDSC_INC_W]; // RL4
   assign wr_code = DDSC_CODE_W'(reg_wdata[RES_BITS-1:0]) << FRAC;
   assign data_wr = reg_wr && ddsc_hit(reg_addr, DDSC_REG_DATA);
   assign ctrl_wr = reg_wr && ddsc_hit(reg_addr, DDSC_REG_CTRL);
   assign clr_rise = clear_in && !clr_q_r;
   assign refused = data_wr && clear_in;

   assign slew_active = slew_en && (code_r != target_r); // RL11
   assign tk.rate = ctrl_r[DDSC_RATE_LSB +: DDSC_RATE_W]; // RL3
   assign tk.run = slew_active;

   // Ramp engine; bus writes are applied after the step of the same cycle
   always_comb begin
      ctrl_nxt = ctrl_r;
      code_nxt = code_r;
      target_nxt = target_r;
      clr_q_nxt = clear_in;
      act_q_nxt = slew_active;
      if (tk.tick && slew_active) begin // RL2 RL10
         if (target_r > code_r) begin
            if (target_r - code_r > step) begin
               code_nxt = code_r + step;
            end else begin
               code_nxt = target_r; // RL13
            end
         end else begin
            if (code_r - target_r > step) begin
               code_nxt = code_r - step;
            end else begin
               code_nxt = target_r; // RL13
            end
         end
      end
      if (clear_in) begin
         if (!slew_en) begin
            code_nxt = DDSC_ZERO_SCALE; // RL12
            target_nxt = DDSC_ZERO_SCALE;
         end else if (clr_rise) begin
            target_nxt = DDSC_ZERO_SCALE; // RL6 RL5
         end
      end else if (data_wr) begin // RL12
         target_nxt = wr_code;
         if (!slew_en) begin
            code_nxt = wr_code; // RL1
         end
      end
      if (ctrl_wr) begin
         ctrl_nxt = reg_wdata[DDSC_CTRL_W-1:0];
         if (slew_active) begin
            target_nxt = code_nxt; // RL7
         end
      end
   end

   always_ff @(posedge mclk) begin
      if (!reset_n) begin
         ctrl_r <= DDSC_CTRL_RST;
         code_r <= DDSC_CODE_RST;
         target_r <= DDSC_CODE_RST;
         clr_q_r <= 1'b0;
         act_q_r <= 1'b0;
      end else begin
         ctrl_r <= ctrl_nxt;
         code_r <= code_nxt;
         target_r <= target_nxt;
         clr_q_r <= clr_q_nxt;
         act_q_r <= act_q_nxt;
      end
   end

   assign dac_code = code_r[DDSC_CODE_W-1 -: RES_BITS];

   // Interrupt status; a new event wins over a same-cycle write-one clear
   always_comb begin
      events = '0;
      events[DDSC_INT_DONE] = act_q_r && !slew_active;
      events[DDSC_INT_REFUSED] = refused;
      events[DDSC_INT_CLEAR] = clr_rise;
      int_nxt = int_r;
      mask_nxt = mask_r;
      if (reg_wr && ddsc_hit(reg_addr, DDSC_REG_INT_STAT)) begin
         int_nxt = int_r & ~reg_wdata[DDSC_INT_W-1:0];
      end
      if (reg_wr && ddsc_hit(reg_addr, DDSC_REG_INT_MASK)) begin
         mask_nxt = reg_wdata[DDSC_INT_W-1:0];
      end
      int_nxt = int_nxt | events;
   end

   always_ff @(posedge mclk) begin
      if (!reset_n) begin
         int_r <= DDSC_INT_RST;
         mask_r <= DDSC_MASK_RST;
      end else begin
         int_r <= int_nxt;
         mask_r <= mask_nxt;
      end
   end

   assign irq = |(int_r & mask_r);

   // Read data stand only in the cycle after the strobe
   always_comb begin
      rdata_nxt = '0;
      if (reg_rd) begin
         unique case (reg_addr)
            DDSC_REG_DATA: rdata_nxt = DDSC_DATA_W'(target_r >> FRAC);
            DDSC_REG_CTRL: rdata_nxt = DDSC_DATA_W'(ctrl_r);
            DDSC_REG_STATUS: begin
               rdata_nxt[DDSC_ST_ACTIVE_BIT] = slew_active; // RL11
               rdata_nxt[DDSC_ST_CLEAR_BIT] = clear_in;
            end
            DDSC_REG_INT_STAT: rdata_nxt = DDSC_DATA_W'(int_r);
            DDSC_REG_INT_MASK: rdata_nxt = DDSC_DATA_W'(mask_r);
            DDSC_REG_CODE: rdata_nxt = DDSC_DATA_W'(dac_code);
            default: rdata_nxt = '0;
         endcase
      end
   end

   always_ff @(posedge mclk) begin
      if (!reset_n) begin
         rdata_r <= '0;
      end else begin
         rdata_r <= rdata_nxt;
      end
   end

   assign reg_rdata = rdata_r;

   property p_direct_load;
      @(posedge mclk) disable iff (!reset_n)
      data_wr && !slew_en && !clear_in && !ctrl_wr
      |=> dac_code == $past(reg_wdata[RES_BITS-1:0]);
   endproperty
   a_direct_load: assert property (p_direct_load) // RL1
      else $error("Direct load did not reach the output");

   property p_paced;
      @(posedge mclk) disable iff (!reset_n)
      $past(slew_en) && $changed(code_r) |-> $past(tk.tick);
   endproperty
   a_paced: assert property (p_paced) // RL5
      else $error("Output moved off an update tick while slewing");

   property p_full_step;
      @(posedge mclk) disable iff (!reset_n)
      tk.tick && slew_active && target_r > code_r && target_r - code_r > step
      |=> code_r == $past(code_r) + $past(step);
   endproperty
   a_full_step: assert property (p_full_step) // RL4
      else $error("Step size does not match the increment field");

   property p_land;
      @(posedge mclk) disable iff (!reset_n)
      tk.tick && slew_active && target_r - code_r <= step && target_r > code_r
      && !reg_wr && !clear_in |=> code_r == target_r ##1 !tk.tick;
   endproperty
   a_land: assert property (p_land) // RL13
      else $error("Final step overshot or missed the target");

   // Only a halt that keeps slew on must hold; a disabling write may load directly next
   property p_halt;
      @(posedge mclk) disable iff (!reset_n)
      ctrl_wr && slew_active && !tk.tick && reg_wdata[DDSC_EN_BIT]
      |=> !slew_active && code_r == $past(code_r) ##1 code_r == $past(code_r, 2);
   endproperty
   a_halt: assert property (p_halt) // RL7
      else $error("Control write did not halt the ramp");

   property p_clear_ramp;
      @(posedge mclk) disable iff (!reset_n)
      clr_rise && slew_en && code_r != DDSC_ZERO_SCALE && !ctrl_wr && !tk.tick
      |=> slew_active && target_r == DDSC_ZERO_SCALE && code_r == $past(code_r);
   endproperty
   a_clear_ramp: assert property (p_clear_ramp) // RL6
      else $error("Clear did not start a ramp to zero scale");

   property p_clear_refuse;
      @(posedge mclk) disable iff (!reset_n)
      clear_in && data_wr && !ctrl_wr |=> target_r != $past(wr_code)
      || $past(wr_code) == DDSC_ZERO_SCALE || $past(target_r) == $past(wr_code);
   endproperty
   a_clear_refuse: assert property (p_clear_refuse) // RL12
      else $error("Data accepted while clear held");

   // With no bus write or clear edge, only a landing tick may end the ramp
   property p_active_end;
      @(posedge mclk) disable iff (!reset_n)
      $fell(slew_active) && !$past(reg_wr) && !$past(clr_rise)
      |-> $past(tk.tick) && code_r == $past(target_r);
   endproperty
   a_active_end: assert property (p_active_end) // RL11
      else $error("Slew active fell before the target was reached");

   property p_done_irq;
      @(posedge mclk) disable iff (!reset_n)
      $fell(slew_active) ##1 1'b1 |-> int_r[DDSC_INT_DONE];
   endproperty
   a_done_irq: assert property (p_done_irq) // RL11
      else $error("Ramp end not flagged in interrupt status");

   property p_step_down;
      @(posedge mclk) disable iff (!reset_n)
      tk.tick && slew_active && code_r > target_r && code_r - target_r > step
      |=> code_r == $past(code_r) - $past(step);
   endproperty
   a_step_down: assert property (p_step_down) // RL4
      else $error("Downward step does not match the increment field");

   property p_clear_direct;
      @(posedge mclk) disable iff (!reset_n)
      clear_in && !slew_en
      |=> code_r == DDSC_ZERO_SCALE && target_r == DDSC_ZERO_SCALE;
   endproperty
   a_clear_direct: assert property (p_clear_direct) // RL12
      else $error("Clear with slew off did not force zero scale");

   property p_refused_flag;
      @(posedge mclk) disable iff (!reset_n)
      clear_in && data_wr |=> int_r[DDSC_INT_REFUSED];
   endproperty
   a_refused_flag: assert property (p_refused_flag) // RL12
      else $error("Refused data write not flagged");

   property p_status_read;
      @(posedge mclk) disable iff (!reset_n)
      reg_rd && ddsc_hit(reg_addr, DDSC_REG_STATUS)
      |=> reg_rdata[DDSC_ST_ACTIVE_BIT] == $past(slew_active)
      && reg_rdata[DDSC_ST_CLEAR_BIT] == $past(clear_in);
   endproperty
   a_status_read: assert property (p_status_read) // RL11
      else $error("Status read does not show slew active");

endmodule : ddsc_slew_ctrl

//--- ddsc_tick_gen.sv
// Slew update tick generator, divides the system clock per rate code
`timescale 1ns/10ps
module ddsc_tick_gen
   import ddsc_pkg::*;
#(
   parameter int CLK_FREQ_HZ = DDSC_CLK_HZ
) (
   input wire logic mclk,
   input wire logic reset_n,
   ddsc_tick_if.gen tk
);

   logic [DDSC_DIV_W-1:0] cnt_r;
   logic [DDSC_DIV_W-1:0] cnt_nxt;
   logic [DDSC_DIV_W-1:0] div;

   // Nearest whole divisor, never below two cycles
   function automatic logic [DDSC_DIV_W-1:0] ddsc_rate_div(input logic [3:0] code);
      int d;
      d = (CLK_FREQ_HZ + DDSC_RATE_HZ[code] / 2) / DDSC_RATE_HZ[code];
      if (d < 2) begin
         d = 2;
      end
      return DDSC_DIV_W'(d);
   endfunction : ddsc_rate_div

   // Same divisor for every output range
   assign div = ddsc_rate_div(tk.rate); // RL3 RL9
   assign tk.tick = tk.run && (cnt_r == div - DDSC_DIV_W'(1));

   // Counter restarts when idle so the first step comes a full period late
   always_comb begin
      cnt_nxt = '0;
      if (tk.run && !tk.tick) begin
         cnt_nxt = cnt_r + DDSC_DIV_W'(1);
      end
   end

   always_ff @(posedge mclk) begin
      if (!reset_n) begin
         cnt_r <= '0;
      end else begin
         cnt_r <= cnt_nxt;
      end
   end

   property p_tick_gap;
      @(posedge mclk) disable iff (!reset_n)
      tk.tick |=> !tk.tick;
   endproperty
   a_tick_gap: assert property (p_tick_gap) // RL3
      else $error("Update ticks closer than the divisor allows");

endmodule : ddsc_tick_gen

//--- ddsc_tick_if.sv
// Update tick request and pulse between controller and tick generator
`timescale 1ns/10ps
interface ddsc_tick_if;
   logic [3:0] rate;
   logic run;
   logic tick;
   modport gen (input rate, input run, output tick);
   modport user (output rate, output run, input tick);
endinterface : ddsc_tick_if

//--- tb_top.sv
// Self-checking bench for the slew controller, 16-bit and 12-bit variants
`timescale 1ns/10ps
module tb_top
   import ddsc_pkg::*;
;
   // Small clock figure keeps every tick divisor short
   localparam int CLK_HZ = 1000000;
   typedef struct {logic [3:0] rate; logic [2:0] inc; logic [15:0] tgt; int steps;} ddsc_row_t;
   ddsc_row_t rows [16] = '{'{4'h0, 3'h0, 16'h0005, 3}, '{4'h1, 3'h1, 16'h000a, 3},
      '{4'h2, 3'h2, 16'h0001, 3}, '{4'h3, 3'h3, 16'h0014, 3}, '{4'h4, 3'h4, 16'h0034, 2},
      '{4'h5, 3'h5, 16'h0000, 2}, '{4'h6, 3'h6, 16'h00c8, 4}, '{4'h7, 3'h7, 16'h0190, 2},
      '{4'h8, 3'h0, 16'h018e, 2}, '{4'h9, 3'h1, 16'h0193, 3}, '{4'ha, 3'h2, 16'h0190, 1},
      '{4'hb, 3'h3, 16'h019a, 2}, '{4'hc, 3'h4, 16'h0180, 2}, '{4'hd, 3'h5, 16'h01c0, 2},
      '{4'he, 3'h6, 16'h0200, 1}, '{4'hf, 3'h7, 16'h0281, 2}};
   logic mclk = 1'b0;
   logic reset_n = 1'b0;
   logic clear_in = 1'b0;
   logic [3:0] reg_addr;
   logic [15:0] reg_wdata;
   logic reg_wr;
   logic reg_rd;
   logic [15:0] reg_rdata;
   logic [15:0] dac_code;
   logic [11:0] dac12;
   logic sa;
   logic sa12;
   logic irq;
   int n_errors = 0;
   int cmp_count = 0;
   int cyc = 0;

   always #4 mclk = ~mclk;

   ddsc_host_model host (.mclk(mclk), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata));
   ddsc_slew_ctrl #(.RES_BITS(16), .CLK_FREQ_HZ(CLK_HZ)) dut (.mclk(mclk), .reset_n(reset_n),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_rdata(reg_rdata), .clear_in(clear_in), .dac_code(dac_code), .slew_active(sa),
      .irq(irq));
   ddsc_slew_ctrl #(.RES_BITS(12), .CLK_FREQ_HZ(CLK_HZ)) dut12 (.mclk(mclk),
      .reset_n(reset_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
      .reg_rd(reg_rd), .reg_rdata(), .clear_in(clear_in), .dac_code(dac12),
      .slew_active(sa12), .irq());

   task automatic close_out();
      $display("compares %0d mismatches %0d", cmp_count, n_errors);
      if (n_errors == 0 && cmp_count > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask : close_out

   task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
      cmp_count++;
      if (got !== exp) begin
         n_errors++;
         $display("BAD %s expected %h seen %h", nm, exp, got);
      end
   endtask : chk

   task automatic rdchk(input logic [3:0] a, input logic [15:0] e);
      logic [15:0] d;
      host.rd(a, d);
      chk("reg_rdata", e, d);
   endtask : rdchk

   function automatic int div_of(input int r);
      int d;
      d = (CLK_HZ + DDSC_RATE_HZ[r] / 2) / DDSC_RATE_HZ[r];
      return (d < 2) ? 2 : d;
   endfunction : div_of

   // Counts cycles of slew active and code changes until the ramp ends
   task automatic measure(input bit sel, output int hi, output int chg);
      logic [15:0] prev;
      logic [15:0] now;
      hi = 0;
      chg = 0;
      #1;
      prev = sel ? {4'h0, dac12} : dac_code;
      for (int i = 0; i < 5000; i++) begin
         now = sel ? {4'h0, dac12} : dac_code;
         if (now !== prev) chg++;
         prev = now;
         if ((sel ? sa12 : sa) !== 1'b1) break;
         hi++;
         @(posedge mclk);
         #1;
      end
   endtask : measure

   task automatic zero_check();
      for (int a = 0; a < 7; a++) rdchk((a == 6) ? 4'hf : 4'(a), 16'h0000);
      chk("dac_code", 16'h0000, dac_code);
      chk("irq", 16'h0000, {15'h0, irq});
   endtask : zero_check

   always @(posedge mclk) begin
      cyc++;
      if (cyc == 20000) begin
         n_errors++;
         close_out();
      end
   end

   initial begin
      int hi;
      int chg;
      logic [15:0] h;
      repeat (2) @(posedge mclk);
      reset_n <= 1'b1;
      zero_check();
      // Two LSB at one sixteenth LSB a tick take 32 ticks in the 12-bit part
      host.wr(DDSC_REG_CTRL, 16'h0080);
      host.wr(DDSC_REG_DATA, 16'h0002);
      measure(1'b1, hi, chg);
      chk("hi12", 16'(32 * div_of(0)), 16'(hi));
      chk("chg12", 16'h0002, 16'(chg));
      chk("code16", 16'h0002, dac_code);
      rdchk(DDSC_REG_INT_STAT, 16'h0001);
      chk("irq_masked", 16'h0000, {15'h0, irq});
      host.wr(DDSC_REG_INT_MASK, 16'h0007);
      #1 chk("irq_on", 16'h0001, {15'h0, irq});
      rdchk(DDSC_REG_INT_MASK, 16'h0007);
      host.wr(DDSC_REG_INT_STAT, 16'h0007);
      #1 chk("irq_off", 16'h0000, {15'h0, irq});
      foreach (rows[i]) begin
         host.wait_idle();
         host.wr(DDSC_REG_CTRL, {8'h00, 1'b1, rows[i].rate, rows[i].inc});
         host.wr(DDSC_REG_DATA, rows[i].tgt);
         measure(1'b0, hi, chg);
         chk("ramp_cycles", 16'(rows[i].steps * div_of(rows[i].rate)), 16'(hi));
         chk("steps", 16'(rows[i].steps), 16'(chg));
         chk("final", rows[i].tgt, dac_code);
         @(posedge mclk);
         #1 chk("irq_done", 16'h0001, {15'h0, irq});
         host.wr(DDSC_REG_INT_STAT, 16'h0001);
      end
      host.wr(DDSC_REG_CTRL, 16'h0080);
      host.wr(DDSC_REG_DATA, 16'h02e5);
      repeat (9) @(posedge mclk);
      host.wr(DDSC_REG_CTRL, 16'h0084);
      #1 h = dac_code;
      chk("halt_active", 16'h0000, {15'h0, sa});
      repeat (40) @(posedge mclk);
      #1 chk("halt_hold", h, dac_code);
      chk("halt_mid", 16'h0001, {15'h0, h > 16'h0281 && h < 16'h02e5});
      rdchk(DDSC_REG_DATA, h);
      rdchk(DDSC_REG_CTRL, 16'h0084);
      host.wr(DDSC_REG_INT_STAT, 16'h0007);
      clear_in <= 1'b1;
      host.wr(DDSC_REG_DATA, 16'h1000);
      #1 chk("clear_ramping", 16'h0001, {15'h0, sa});
      measure(1'b0, hi, chg);
      chk("clear_code", 16'h0000, dac_code);
      rdchk(DDSC_REG_STATUS, 16'h0002);
      rdchk(DDSC_REG_INT_STAT, 16'h0007);
      host.wr(DDSC_REG_INT_STAT, 16'h0007);
      host.wr(DDSC_REG_CTRL, 16'h0000);
      clear_in <= 1'b0;
      host.wr(DDSC_REG_DATA, 16'h1234);
      #1 chk("direct", 16'h1234, dac_code);
      rdchk(DDSC_REG_CODE, 16'h1234);
      @(posedge mclk);
      clear_in <= 1'b1;
      repeat (2) @(posedge mclk);
      #1 chk("clear_direct", 16'h0000, dac_code);
      // Leave control and mask non-zero so the mid-run reset has something to clear
      host.wr(DDSC_REG_CTRL, 16'h00bf);
      @(posedge mclk);
      clear_in <= 1'b0;
      reset_n <= 1'b0;
      repeat (2) @(posedge mclk);
      reset_n <= 1'b1;
      zero_check();
      close_out();
   end
endmodule : tb_top
